// >>> core/sap_adc_readout.sv
// Functional notes
// (R1) conversion self-timed, done within 273 ns
// (R2) result is 14-bit straight binary
// (R3) drive outputs only with select and read low
// (R4) otherwise result lines high impedance
// (R5) host avoids reads near trigger falling edge
// (R6) byte select low: full word, msb top
// (R7) 8-bit host reads upper lines twice
// (R8) byte select high: six low bits, zeros
// (R9) byte reads work with strobe pulsed or held
// (R10) reset input aborts conversion within 45 ns; code aborts 40 to 60 ns after the pin falls, through the sync
// (R11) reset phase presents code 3F80
// (R12) short reset pulse resumes without delay
// (R13) first four results after reset invalid
// (R14) host resets after supply reaches 95 percent
// (R15) long reset low enters powerdown
// (R16) powerdown exit waits wake delay
// (R17) busy high throughout each conversion
// (R18) select fall while busy and trigger high aborts
// (R19) host reads after busy low, checks 3F80
`timescale 1ns/1ps
`default_nettype none
module sap_adc_readout
  import sap_pkg::*;
#(
  parameter int unsigned SHUTDOWN_CYC = SHUTDOWN_CYCLES,
  parameter int unsigned WAKE_CYC = WAKE_CYCLES
)
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic conversion_trigger_n_i,
  input wire logic chip_select_n_i,
  input wire logic read_n_i,
  input wire logic byte_select_i,
  input wire logic sleep_or_init_n_i,
  input wire logic [RES_W-1:0] sample_code_i,
  output logic busy_o,
  output logic powered_down_o,
  output logic result_valid_o,
  output logic [RES_W-1:0] result_bus_lines_o,
  output logic [RES_W-1:0] result_bus_lines_oe_o
);
  // pin synchronisers: stage one feeds only stage two
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic [4:0] pin_d_reg;
  logic [4:0] pin_raw;
  logic trig_n;
  logic cs_n;
  logic rd_n;
  logic byte_sel;
  logic slp_n;

  // raw pins gathered so each synchroniser bit can pick its own
  assign pin_raw = {sleep_or_init_n_i, byte_select_i, read_n_i, chip_select_n_i, conversion_trigger_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys_i)
      begin
        if (!nrst_i)
        begin
          pin_s1_reg[gi] <= 1'b1;
          pin_s2_reg[gi] <= 1'b1;
          pin_d_reg[gi] <= 1'b1;
        end
        else
        begin
          pin_s1_reg[gi] <= pin_raw[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
          pin_d_reg[gi] <= pin_s2_reg[gi];
        end
      end
    end
  endgenerate

  assign trig_n = pin_s2_reg[0];
  assign cs_n = pin_s2_reg[1];
  assign rd_n = pin_s2_reg[2];
  assign byte_sel = pin_s2_reg[3];
  assign slp_n = pin_s2_reg[4];

  // edge events on synchronised pins
  logic trig_fall;
  logic cs_fall;
  logic slp_fall;
  logic slp_rise;
  assign trig_fall = pin_d_reg[0] && !trig_n;
  assign cs_fall = pin_d_reg[1] && !cs_n;
  assign slp_fall = pin_d_reg[4] && !slp_n;
  assign slp_rise = !pin_d_reg[4] && slp_n;

  // conversion and reset sequencer
  sap_state_t state_reg;
  sap_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [2:0] warm_reg;
  logic [2:0] warm_next;
  logic [RES_W-1:0] shown_reg;
  logic [RES_W-1:0] shown_next;
  logic push;
  logic [RES_W:0] push_data;
  logic buf_ready;
  logic buf_valid;
  logic [RES_W:0] buf_data;
  logic flush;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    warm_next = warm_reg;
    shown_next = shown_reg;
    push = 1'b0;
    push_data = {1'b0, CODE_ZERO};
    flush = 1'b0;
    if (slp_fall)
    begin
      // abort on the edge after sync, 40 to 60 ns after the pin falls against the 45 ns bound
      state_next = ST_RESET; // (R10)
      cnt_next = '0;
      shown_next = CODE_RESET; // (R11)
      flush = 1'b1;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (trig_fall)
          begin
            state_next = ST_CONV;
            cnt_next = '0;
          end
        end
        ST_CONV:
        begin
          cnt_next = cnt_reg + 1'b1;
          if (cs_fall && !trig_n)
          begin
            state_next = ST_CONV;
          end
          if (cs_fall && trig_n)
          begin
            state_next = ST_IDLE; // (R18)
            shown_next = CODE_RESET; // (R18)
          end
          else if (cnt_reg == CNT_W'(CONV_CYCLES - 1))
          begin
            // self-timed end, no host clock needed
            state_next = ST_IDLE; // (R1)
            shown_next = sample_code_i; // (R2)
            // a full buffer means the host fell behind; the word is still shown on the bus
            push = buf_ready;
            push_data = {(warm_reg == INVALID_CONVERSIONS), sample_code_i}; // (R13)
            if (warm_reg != INVALID_CONVERSIONS)
              warm_next = warm_reg + 1'b1;
          end
        end
        ST_RESET:
        begin
          cnt_next = cnt_reg + 1'b1;
          if (slp_rise)
          begin
            state_next = ST_IDLE; // (R12)
            warm_next = '0;
          end
          else if (cnt_reg == CNT_W'(SHUTDOWN_CYC))
          begin
            state_next = ST_POWERDOWN; // (R15)
          end
        end
        ST_POWERDOWN:
        begin
          if (slp_rise)
          begin
            state_next = ST_WAKE;
            cnt_next = '0;
            warm_next = '0;
          end
        end
        ST_WAKE:
        begin
          cnt_next = cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(WAKE_CYC - 1))
            state_next = ST_IDLE; // (R16)
        end
        default:
        begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      warm_reg <= 3'h0;
      shown_reg <= CODE_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      warm_reg <= warm_next;
      shown_reg <= shown_next;
    end
  end

  // results queue for the side stream; each read strobe fall with select low retires one word
  logic rd_take;
  assign rd_take = !cs_n && pin_d_reg[2] && !rd_n;

  sap_skid_buf u_buf (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .flush_i(flush),
    .in_valid_i(push),
    .in_ready_o(buf_ready),
    .in_data_i(push_data),
    .out_valid_o(buf_valid),
    .out_ready_i(rd_take),
    .out_data_o(buf_data)
  );

  // busy and status outputs
  assign busy_o = (state_reg == ST_CONV); // (R17)
  assign powered_down_o = (state_reg == ST_POWERDOWN);
  assign result_valid_o = buf_valid && buf_data[RES_W];

  // output word and enables; byte select alone picks the half, strobe style irrelevant
  logic [RES_W-1:0] word;
  logic show_reset;
  logic [RES_W-1:0] bus_reg;
  logic [RES_W-1:0] bus_next;
  assign show_reset = (state_reg == ST_RESET);

  // next data word for the pins
  always_comb
  begin
    word = show_reset ? CODE_RESET : shown_reg; // (R11)
    if (byte_sel)
      bus_next = {word[LOW_W-1:0], 2'h0, 6'h00}; // (R8)
    else
      bus_next = word; // (R6)
  end

  // data pins from a flop: one cycle more latency, but no glitch on a state change
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
      bus_reg <= CODE_ZERO;
    else
      bus_reg <= bus_next;
  end

  assign result_bus_lines_o = bus_reg;

  // enables track synchronised select and read; the byte half follows byte select on every cycle (R9)
  assign result_bus_lines_oe_o = (!cs_n && !rd_n) ? {RES_W{1'b1}} : {RES_W{1'b0}}; // (R3) (R4)
endmodule : sap_adc_readout
`default_nettype wire

// >>> core/sap_pkg.sv
package sap_pkg;
  // clock rate and conversion timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CONV_TIME_MAX_NS = 273;
  // longest time rounds down, at least one cycle
  localparam int unsigned CONV_CYCLES_RAW = CONV_TIME_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
  localparam int unsigned ABORT_TIME_MAX_NS = 45;
  localparam int unsigned ABORT_CYCLES_RAW = ABORT_TIME_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned ABORT_CYCLES = (ABORT_CYCLES_RAW < 1) ? 1 : ABORT_CYCLES_RAW;
  // powerdown threshold and wake delay; plain defaults
  localparam int unsigned SHUTDOWN_THRESHOLD_TIME_NS = 1000;
  localparam int unsigned SHUTDOWN_CYCLES = SHUTDOWN_THRESHOLD_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned WAKE_DELAY_NS = 1000;
  localparam int unsigned WAKE_CYCLES = WAKE_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned RES_W = 14;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned LOW_W = 6;
  localparam logic [RES_W-1:0] CODE_FULL = 14'h3FFF;
  localparam logic [RES_W-1:0] CODE_ZERO = 14'h0000;
  localparam logic [RES_W-1:0] CODE_RESET = 14'h3F80;
  localparam logic [2:0] INVALID_CONVERSIONS = 3'h4;
  typedef enum logic [2:0] {ST_IDLE, ST_CONV, ST_RESET, ST_POWERDOWN, ST_WAKE} sap_state_t;
endpackage : sap_pkg

// >>> core/sap_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
// two-entry buffer; input ready drops only when both slots are full
module sap_skid_buf
  import sap_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [RES_W:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [RES_W:0] out_data_o
);
  logic [RES_W:0] slot_reg [2];
  logic [RES_W:0] slot_next [2];
  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o = slot_reg[0];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // slot 0 is always the head; shift on pop
  always_comb
  begin
    slot_next[0] = slot_reg[0];
    slot_next[1] = slot_reg[1];
    count_next = count_reg;
    if (flush_i)
    begin
      count_next = 2'h0;
    end
    else
    begin
      if (pop)
      begin
        slot_next[0] = slot_reg[1];
      end
      if (push)
      begin
        if (count_reg == 2'h0 || (count_reg == 2'h1 && pop))
          slot_next[0] = in_data_i;
        else
          slot_next[1] = in_data_i;
      end
      count_next = count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      count_reg <= 2'h0;
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
    end
    else
    begin
      count_reg <= count_next;
      slot_reg[0] <= slot_next[0];
      slot_reg[1] <= slot_next[1];
    end
  end
endmodule : sap_skid_buf
`default_nettype wire

// >>> dv/sap_adc_readout_props.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level checks on the system clock
module sap_adc_readout_props
  import sap_pkg::*;
#(
  parameter int unsigned SHUTDOWN_CYC = SHUTDOWN_CYCLES,
  parameter int unsigned WAKE_CYC = WAKE_CYCLES
)
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic conversion_trigger_n_i,
  input wire logic chip_select_n_i,
  input wire logic read_n_i,
  input wire logic byte_select_i,
  input wire logic sleep_or_init_n_i,
  input wire logic busy_o,
  input wire logic powered_down_o,
  input wire logic [RES_W-1:0] result_bus_lines_o,
  input wire logic [RES_W-1:0] result_bus_lines_oe_o
);
  int unsigned low_cnt;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  // length of the powerdown pin's low spell; margin covers the pin sync
  always_ff @(posedge clk_sys_i)
    low_cnt <= (!nrst_i || sleep_or_init_n_i) ? 0 : low_cnt + 1;
  a_conv_time_bound: assert property ($rose(busy_o) |-> ##[1:13] !busy_o)
    else $error("conversion too long");
  a_busy_after_trig: assert property ((sleep_or_init_n_i && !powered_down_o)[*6] ##0
    ($fell(conversion_trigger_n_i) && !busy_o) |-> ##[1:4] busy_o) else $error("busy late");
  a_oe_on_read: assert property ((!chip_select_n_i && !read_n_i)[*4] |-> &result_bus_lines_oe_o)
    else $error("bus not driven");
  a_hiz_idle: assert property ((chip_select_n_i || read_n_i)[*4] |-> result_bus_lines_oe_o == '0)
    else $error("bus not released");
  a_low_byte_zero: assert property ((byte_select_i && !chip_select_n_i && !read_n_i)[*4]
    |-> result_bus_lines_o[7:0] == 8'h00) else $error("low lines not zero");
  a_abort_on_sleep: assert property ((!sleep_or_init_n_i)[*4] |-> !busy_o)
    else $error("conversion not aborted");
  a_reset_code_shown: assert property ($fell(sleep_or_init_n_i) ##1
    (!sleep_or_init_n_i && !byte_select_i)[*4] |-> result_bus_lines_o == CODE_RESET)
    else $error("no reset code");
  a_pd_entry: assert property (low_cnt > SHUTDOWN_CYC + 4 |-> powered_down_o)
    else $error("no powerdown");
endmodule : sap_adc_readout_props
bind sap_adc_readout sap_adc_readout_props #(.SHUTDOWN_CYC(SHUTDOWN_CYC), .WAKE_CYC(WAKE_CYC)) u_props (
  .clk_sys_i, .nrst_i, .conversion_trigger_n_i, .chip_select_n_i, .read_n_i, .byte_select_i,
  .sleep_or_init_n_i, .busy_o, .powered_down_o, .result_bus_lines_o, .result_bus_lines_oe_o);
`default_nettype wire

// >>> dv/sap_adc_readout_test.sv
`timescale 1ns/1ps
`default_nettype none
module sap_adc_readout_test;
  import sap_pkg::*;
  localparam int unsigned SD = 40;
  localparam int unsigned WK = 6;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic look = 1'b0;
  logic [RES_W-1:0] code = '0;
  logic trig_n, cs_n, rd_n, bsel, sleep_n, busy, pd, valid;
  logic [RES_W-1:0] data, oe, bus;
  logic [18:0] exp_q[$];
  logic [18:0] msk_q[$];
  int miscompares = 0;
  int n_checks = 0;
  wire [18:0] obs = {valid, busy, pd, &oe, |oe, bus};
  always #10 clk_sys_i = ~clk_sys_i;
  sap_adc_readout #(.SHUTDOWN_CYC(SD), .WAKE_CYC(WK)) uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .conversion_trigger_n_i(trig_n), .chip_select_n_i(cs_n), .read_n_i(rd_n), .byte_select_i(bsel),
    .sleep_or_init_n_i(sleep_n), .sample_code_i(code), .busy_o(busy), .powered_down_o(pd),
    .result_valid_o(valid), .result_bus_lines_o(data), .result_bus_lines_oe_o(oe));
  sap_host_model host (.clk_sys_i(clk_sys_i), .data_i(data), .oe_i(oe), .trig_n_o(trig_n), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .bsel_o(bsel), .sleep_n_o(sleep_n), .bus_o(bus));
  // oldest note against the settled outputs
  always @(posedge clk_sys_i)
    if (look)
    begin
      n_checks++;
      if ((obs & msk_q[0]) !== exp_q[0])
      begin
        miscompares++;
        $display("Error t=%0t exp=%h got=%h", $time, exp_q[0], obs & msk_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // an idle edge follows each note so look is never set twice at once
  task automatic note(input logic [18:0] e, input logic [18:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    look <= 1'b1;
    @(posedge clk_sys_i);
    look <= 1'b0;
    @(posedge clk_sys_i);
  endtask : note
  task automatic wait_busy(input logic lvl);
    int i;
    i = 0;
    while (busy !== lvl)
    begin
      @(posedge clk_sys_i);
      i++;
      if (i > 40)
      begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask : wait_busy
  task automatic convert(input logic [RES_W-1:0] w);
    code <= w;
    host.start_conv();
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask : convert
  // whole word, then low byte; strobe pulsed between halves or held low
  task automatic read_word(input logic [RES_W-1:0] w, input logic pulse);
    host.pins(1'b0, 1'b0, 1'b0, sleep_n);
    repeat (3) @(posedge clk_sys_i);
    note({5'h03, w}, 19'h2_FFFF);
    if (pulse)
      host.pins(1'b0, 1'b1, 1'b0, sleep_n);
    host.pins(1'b0, 1'b0, 1'b1, sleep_n);
    repeat (3) @(posedge clk_sys_i);
    note({5'h03, w[5:0], 8'h00}, 19'h2_FFFF);
    host.pins(1'b1, 1'b1, 1'b0, sleep_n);
    repeat (3) @(posedge clk_sys_i);
    note(19'h0_0000, 19'h0_C000);
  endtask : read_word
  initial
  begin
    logic [RES_W-1:0] w;
    void'($urandom(87345));
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    // boundary codes then random ones; first four flagged invalid
    for (int i = 0; i < 6; i++)
    begin
      w = (i == 0) ? CODE_FULL : (i == 1) ? 14'h1FFF : (i == 2) ? CODE_ZERO : 14'($urandom());
      convert(w);
      note({i >= 4, 18'h0_0000}, 19'h7_0000);
      read_word(w, i[0]);
    end
    // select falls mid-conversion with the trigger high
    host.start_conv();
    wait_busy(1'b1);
    host.pins(1'b0, 1'b1, 1'b0, 1'b1);
    wait_busy(1'b0);
    read_word(CODE_RESET, 1'b0);
    // short reset pulse in mid-conversion
    host.start_conv();
    wait_busy(1'b1);
    host.pins(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge clk_sys_i);
    note(19'h0_0000, 19'h2_0000);
    read_word(CODE_RESET, 1'b0);
    host.pins(1'b1, 1'b1, 1'b0, 1'b1);
    convert(CODE_FULL);
    // long low spell, then wake
    host.pins(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (SD + 8) @(posedge clk_sys_i);
    note(19'h1_0000, 19'h3_0000);
    host.pins(1'b1, 1'b1, 1'b0, 1'b1);
    repeat (WK + 6) @(posedge clk_sys_i);
    note(19'h0_0000, 19'h1_0000);
    convert(CODE_ZERO);
    report_and_stop();
  end
endmodule : sap_adc_readout_test
`default_nettype wire

// >>> dv/sap_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host: owns the control pins and resolves the shared result lines
module sap_host_model
  import sap_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [RES_W-1:0] data_i,
  input wire logic [RES_W-1:0] oe_i,
  output logic trig_n_o = 1'b1,
  output logic cs_n_o = 1'b1,
  output logic rd_n_o = 1'b1,
  output logic bsel_o = 1'b0,
  output logic sleep_n_o = 1'b1,
  output logic [RES_W-1:0] bus_o
);
  logic [RES_W-1:0] last = '0;
  // keep each line's last driven level; a released line shows its inverse, never a stale copy
  always_ff @(posedge clk_sys_i)
    last <= (data_i & oe_i) | (last & ~oe_i);
  assign bus_o = (data_i & oe_i) | (~last & ~oe_i);
  // trigger low two edges, only while idle and clear of reads
  task automatic start_conv();
    trig_n_o <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    trig_n_o <= 1'b1;
  endtask : start_conv
  // one edge of select, strobe, byte and powerdown levels
  task automatic pins(input logic cs, rd, bsel, slp);
    cs_n_o <= cs;
    rd_n_o <= rd;
    bsel_o <= bsel;
    sleep_n_o <= slp;
    @(posedge clk_sys_i);
  endtask : pins
endmodule : sap_host_model
`default_nettype wire
